// ==== pkg/asp_defs.svh ====
// Offsets, field positions, reset values and timing counts for the serial port
// Assumes inclusion by bare name from design files
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_ADDR_CTRL 4'h0
`define ASP_ADDR_DATA 4'h4
`define ASP_ADDR_STAT 4'h8
`define ASP_CTRL_MODE_LO 0
`define ASP_CTRL_MODE_HI 1
`define ASP_CTRL_RX_EN 2
`define ASP_CTRL_MP_EN 3
`define ASP_CTRL_TX9 4
`define ASP_CTRL_RX9 5
`define ASP_CTRL_TXDONE 6
`define ASP_CTRL_RXFULL 7
`define ASP_CTRL_DBL 8
`define ASP_CTRL_TXSRC 9
`define ASP_CTRL_RXSRC 10
`define ASP_STAT_TXBUSY 0
`define ASP_STAT_RXBUSY 1
`define ASP_CTRL_RESET 11'h000
`define ASP_SHREG_ONES 9'h1ff
`define ASP_SAMP_A 4'h7
`define ASP_SAMP_B 4'h8
`define ASP_SAMP_C 4'h9
`define ASP_DIV_LAST 4'hf
`endif

// ==== pkg/asp_pkg.sv ====
// Types shared by the serial port design
// Assumes no surroundings beyond a SystemVerilog compiler
package asp_pkg;
    typedef enum logic [1:0] {ASP_MODE_SYNC, ASP_MODE_ONE, ASP_MODE_TWO, ASP_MODE_THREE}
        asp_mode_t;
    typedef enum logic [1:0] {ASP_TX_IDLE, ASP_TX_WAIT, ASP_TX_START, ASP_TX_DATA} asp_tx_st_t;
    typedef enum logic [1:0] {ASP_RX_HUNT, ASP_RX_BITS, ASP_RX_TAIL} asp_rx_st_t;
endpackage

// ==== rtl/asp_serial_port.sv ====
// Asynchronous serial port, framed modes one to three, with Wishbone slave
// Assumes 16x baud ticks from outside timers and a single 250 MHz clock
//
// Summary of operation
// - Start bit first, data path one bit time later, first shift after another.
// - Mode 1 tx shifts in zeros; done flag at tenth rollover after write.
// - Start found as falling edge on rx pin sampled at the system clock rate.
// - On start edge, reset divide-by-16 counter and load all ones.
// - Sample rx at counter states seven, eight, nine; take majority.
// - First bit not zero rejects frame and resumes hunting.
// - Nine-bit rx register; start bit leftmost triggers final shift and decision.
// - Mode 1 loads data, stop into ninth flag, if flag clear and filter passes.
// - Mode 1 returns to hunting at final shift, accepted or not.
// - Modes 2 and 3 use eleven-bit frames with programmable ninth bit.
// - Mode 2 rate is osc/32 or osc/64; mode 3 from selected timer.
// - Modes 2,3 write copies ninth bit and starts after next rollover.
// - Modes 2,3 first shift inserts one at position nine, then zeros.
// - Modes 2,3 done flag set at eleventh rollover after write.
// - Modes 2,3 load data and ninth bit if flag clear and filter passes.
// - Modes 2,3 hunting resumes one bit time after final shift.
// - Modes 2,3 ignore received stop bit value.
// - Interrupt request is OR of both flags, never auto-cleared.
// - Software set or clear of flags acts like hardware.
// - Mode 1 uses ten-bit frames.
// - Mode 1 write loads one at position nine, starts after next rollover.
// - Timer-one rate scaled by two to double-rate bit over thirty-two.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_serial_port #(
    parameter int OSC_DIV_W = 6
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic wb_we_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic tmr1_ovf_in,
    input wire logic tmr2_ovf_in,
    input wire logic rxd_in,
    output logic txd_out,
    output logic serial_irq_out
);
    // Control register state
    logic [10:0] ctrl_r, ctrl_nxt;
    logic [7:0] serial_buffer_r, serial_buffer_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic ack_r, ack_nxt;
    logic irq_r, irq_nxt;
    asp_pkg::asp_mode_t mode;
    logic wr_data, wr_ctrl;
    // Baud tick generation state
    logic [OSC_DIV_W-1:0] osc_div_r, osc_div_nxt;
    logic t1_half_r, t1_half_nxt;
    logic tx_tick, rx_tick;
    // Transmit state
    asp_pkg::asp_tx_st_t tx_st_r, tx_st_nxt;
    logic [3:0] tx_div_r, tx_div_nxt;
    logic [8:0] tx_sh_r, tx_sh_nxt;
    logic tx_first_r, tx_first_nxt;
    logic txd_r, txd_nxt;
    logic tx_set;
    // Receive state
    asp_pkg::asp_rx_st_t rx_st_r, rx_st_nxt;
    logic [3:0] rx_div_r, rx_div_nxt;
    logic [8:0] rx_sh_r, rx_sh_nxt;
    logic [2:0] rx_samp_r, rx_samp_nxt;
    logic rx_first_r, rx_first_nxt;
    logic [7:0] rx_data_r, rx_data_nxt;
    logic rx_set, rx_load9;
    logic [2:0] rxd_sync_r;
    logic rxd_clean_r, rxd_clean_nxt;
    logic rxd_prev_r, rxd_prev_nxt;
    logic rx_vote;

    // Pin synchroniser, three stages; change counts when last two agree
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rxd_sync_r <= 3'h7;
        end else begin
            rxd_sync_r <= {rxd_sync_r[1:0], rxd_in};
        end
    end
    always_comb begin
        rxd_clean_nxt = rxd_clean_r;
        if (rxd_sync_r[1] == rxd_sync_r[2]) begin
            rxd_clean_nxt = rxd_sync_r[2];
        end
    end

    assign mode = asp_pkg::asp_mode_t'(ctrl_r[`ASP_CTRL_MODE_HI:`ASP_CTRL_MODE_LO]);
    assign wr_ctrl = wb_cyc_in && wb_stb_in && wb_we_in && !ack_r && wb_sel_in[0]
        && (wb_adr_in == `ASP_ADDR_CTRL);
    assign wr_data = wb_cyc_in && wb_stb_in && wb_we_in && !ack_r && wb_sel_in[0]
        && (wb_adr_in == `ASP_ADDR_DATA);

    // Baud ticks: mode 2 from oscillator divider, modes 1 and 3 from timers
    always_comb begin
        osc_div_nxt = osc_div_r + 1'b1;
        t1_half_nxt = t1_half_r ^ tmr1_ovf_in;
        tx_tick = 1'b0;
        rx_tick = 1'b0;
        if (mode == asp_pkg::ASP_MODE_TWO) begin
            // 16x tick every 2 or 4 clocks: bit rate osc/32 or osc/64
            tx_tick = ctrl_r[`ASP_CTRL_DBL] ? (osc_div_r[0] == 1'b1)
                : (osc_div_r[1:0] == 2'b11);
            rx_tick = tx_tick;
        end else begin
            // Timer 1 overflow halved unless double rate set
            tx_tick = ctrl_r[`ASP_CTRL_TXSRC] ? tmr2_ovf_in
                : (tmr1_ovf_in && (ctrl_r[`ASP_CTRL_DBL] || t1_half_r));
            rx_tick = ctrl_r[`ASP_CTRL_RXSRC] ? tmr2_ovf_in
                : (tmr1_ovf_in && (ctrl_r[`ASP_CTRL_DBL] || t1_half_r));
        end
    end

    // Transmit sequencer
    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_div_nxt = tx_tick ? tx_div_r + 4'h1 : tx_div_r;
        tx_sh_nxt = tx_sh_r;
        tx_first_nxt = tx_first_r;
        txd_nxt = txd_r;
        tx_set = 1'b0;
        case (tx_st_r)
            asp_pkg::ASP_TX_IDLE: begin
                txd_nxt = 1'b1;
            end
            asp_pkg::ASP_TX_WAIT: begin
                // Begin after next rollover of the divide-by-16 counter
                if (tx_tick && tx_div_r == `ASP_DIV_LAST) begin
                    tx_st_nxt = asp_pkg::ASP_TX_START;
                    txd_nxt = 1'b0;
                end
            end
            asp_pkg::ASP_TX_START: begin
                if (tx_tick && tx_div_r == `ASP_DIV_LAST) begin
                    tx_st_nxt = asp_pkg::ASP_TX_DATA;
                    txd_nxt = tx_sh_r[0];
                end
            end
            asp_pkg::ASP_TX_DATA: begin
                if (tx_tick && tx_div_r == `ASP_DIV_LAST) begin
                    // Marker beside MSB or ninth bit: last shift, done
                    if (tx_sh_r[8:2] == 7'h00 && tx_sh_r[1] && !tx_first_r) begin
                        tx_st_nxt = asp_pkg::ASP_TX_IDLE;
                        txd_nxt = 1'b1;
                        tx_set = 1'b1;
                        tx_sh_nxt = 9'h000;
                    end else begin
                        // First shift in modes 2,3 inserts stop bit
                        tx_sh_nxt = {tx_first_r, tx_sh_r[8:1]};
                        tx_first_nxt = 1'b0;
                        txd_nxt = tx_sh_r[1];
                    end
                end
            end
            default: begin
                tx_st_nxt = asp_pkg::ASP_TX_IDLE;
            end
        endcase
        if (wr_data) begin
            // Ninth position: one in mode 1, tx ninth bit otherwise
            tx_sh_nxt = {(mode == asp_pkg::ASP_MODE_ONE) ? 1'b1 : ctrl_r[`ASP_CTRL_TX9],
                wb_dat_in[7:0]};
            tx_first_nxt = (mode != asp_pkg::ASP_MODE_ONE);
            tx_st_nxt = asp_pkg::ASP_TX_WAIT;
        end
    end

    // Receive register holds the first data bit in bit seven, below the start bit; buffer wants it in bit zero
    logic [7:0] rx_sh_rev;
    for (genvar g = 0; g < 8; g++) begin : g_rx_rev
        assign rx_sh_rev[g] = rx_sh_r[7 - g];
    end

    assign rx_vote = (rx_samp_r[0] & rx_samp_r[1]) | (rx_samp_r[0] & rx_samp_r[2])
        | (rx_samp_r[1] & rx_samp_r[2]);

    // Receive sequencer
    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_div_nxt = rx_tick ? rx_div_r + 4'h1 : rx_div_r;
        rx_sh_nxt = rx_sh_r;
        rx_samp_nxt = rx_samp_r;
        rx_first_nxt = rx_first_r;
        rx_data_nxt = rx_data_r;
        rxd_prev_nxt = rxd_clean_r;
        rx_set = 1'b0;
        rx_load9 = 1'b0;
        case (rx_st_r)
            asp_pkg::ASP_RX_HUNT: begin
                // Falling edge while enabled, seen at clock rate >= 16x
                if (ctrl_r[`ASP_CTRL_RX_EN] && mode != asp_pkg::ASP_MODE_SYNC
                        && rxd_prev_r && !rxd_clean_r) begin
                    rx_div_nxt = 4'h0;
                    rx_sh_nxt = `ASP_SHREG_ONES;
                    rx_first_nxt = 1'b1;
                    rx_st_nxt = asp_pkg::ASP_RX_BITS;
                end
            end
            asp_pkg::ASP_RX_BITS: begin
                if (rx_tick) begin
                    // Three samples mid-bit
                    if (rx_div_r == `ASP_SAMP_A) rx_samp_nxt[0] = rxd_clean_r;
                    if (rx_div_r == `ASP_SAMP_B) rx_samp_nxt[1] = rxd_clean_r;
                    if (rx_div_r == `ASP_SAMP_C) rx_samp_nxt[2] = rxd_clean_r;
                    if (rx_div_r == `ASP_DIV_LAST) begin
                        rx_first_nxt = 1'b0;
                        if (rx_first_r && rx_vote) begin
                            rx_st_nxt = asp_pkg::ASP_RX_HUNT;
                        end else if (!rx_sh_r[8]) begin
                            // Start bit leftmost: final shift and decision
                            rx_sh_nxt = {rx_sh_r[7:0], rx_vote};
                            // Mode 1 uses stop bit, modes 2,3 the ninth bit
                            if (!ctrl_r[`ASP_CTRL_RXFULL]
                                    && (!ctrl_r[`ASP_CTRL_MP_EN] || rx_vote)) begin
                                rx_set = 1'b1;
                                rx_load9 = rx_vote;
                                rx_data_nxt = rx_sh_rev;
                            end
                            // Mode 1 hunts at once; modes 2,3 wait out stop
                            rx_st_nxt = (mode == asp_pkg::ASP_MODE_ONE) ? asp_pkg::ASP_RX_HUNT
                                : asp_pkg::ASP_RX_TAIL;
                        end else begin
                            rx_sh_nxt = {rx_sh_r[7:0], rx_vote};
                        end
                    end
                end
            end
            asp_pkg::ASP_RX_TAIL: begin
                // Stop bit time passes unexamined
                if (rx_tick && rx_div_r == `ASP_DIV_LAST) begin
                    rx_st_nxt = asp_pkg::ASP_RX_HUNT;
                end
            end
            default: begin
                rx_st_nxt = asp_pkg::ASP_RX_HUNT;
            end
        endcase
    end

    // Control register, flags and bus answers; hardware set beats software clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        serial_buffer_nxt = serial_buffer_r;
        rdat_nxt = 32'h0000_0000;
        ack_nxt = wb_cyc_in && wb_stb_in && !ack_r;
        if (wr_ctrl) begin
            ctrl_nxt[7:0] = wb_dat_in[7:0];
        end
        if (wr_ctrl && wb_sel_in[1]) begin
            ctrl_nxt[10:8] = wb_dat_in[10:8];
        end
        if (tx_set) begin
            ctrl_nxt[`ASP_CTRL_TXDONE] = 1'b1;
        end
        if (rx_set) begin
            ctrl_nxt[`ASP_CTRL_RXFULL] = 1'b1;
            ctrl_nxt[`ASP_CTRL_RX9] = rx_load9;
            serial_buffer_nxt = rx_data_nxt;
        end
        if (wb_cyc_in && wb_stb_in && !wb_we_in && !ack_r) begin
            case (wb_adr_in)
                `ASP_ADDR_CTRL: rdat_nxt = {21'h000000, ctrl_r};
                `ASP_ADDR_DATA: rdat_nxt = {24'h000000, serial_buffer_r};
                `ASP_ADDR_STAT: rdat_nxt = {30'h00000000,
                    rx_st_r != asp_pkg::ASP_RX_HUNT, tx_st_r != asp_pkg::ASP_TX_IDLE};
                default: rdat_nxt = 32'h0000_0000;
            endcase
        end
        // Request is OR of flags; nothing here clears them
        irq_nxt = ctrl_nxt[`ASP_CTRL_TXDONE] | ctrl_nxt[`ASP_CTRL_RXFULL];
    end

    // All state registers except the pin synchroniser
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_r <= `ASP_CTRL_RESET;
            serial_buffer_r <= 8'h00;
            rdat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            irq_r <= 1'b0;
            osc_div_r <= '0;
            t1_half_r <= 1'b0;
            tx_st_r <= asp_pkg::ASP_TX_IDLE;
            tx_div_r <= 4'h0;
            tx_sh_r <= 9'h000;
            tx_first_r <= 1'b0;
            txd_r <= 1'b1;
            rx_st_r <= asp_pkg::ASP_RX_HUNT;
            rx_div_r <= 4'h0;
            rx_sh_r <= `ASP_SHREG_ONES;
            rx_samp_r <= 3'h7;
            rx_first_r <= 1'b0;
            rx_data_r <= 8'h00;
            rxd_clean_r <= 1'b1;
            rxd_prev_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            serial_buffer_r <= serial_buffer_nxt;
            rdat_r <= rdat_nxt;
            ack_r <= ack_nxt;
            irq_r <= irq_nxt;
            osc_div_r <= osc_div_nxt;
            t1_half_r <= t1_half_nxt;
            tx_st_r <= tx_st_nxt;
            tx_div_r <= tx_div_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_first_r <= tx_first_nxt;
            txd_r <= txd_nxt;
            rx_st_r <= rx_st_nxt;
            rx_div_r <= rx_div_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_samp_r <= rx_samp_nxt;
            rx_first_r <= rx_first_nxt;
            rx_data_r <= rx_data_nxt;
            rxd_clean_r <= rxd_clean_nxt;
            rxd_prev_r <= rxd_prev_nxt;
        end
    end

    assign wb_dat_out = rdat_r;
    assign wb_ack_out = ack_r;
    assign txd_out = txd_r;
    assign serial_irq_out = irq_r;

    // Interrupt level mirrors the two flags in every cycle
    a_irq_follows_flags: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        serial_irq_out == (ctrl_r[`ASP_CTRL_TXDONE] | ctrl_r[`ASP_CTRL_RXFULL]))
        else $error("irq not OR of flags");
    // Transmit line sequence
    a_tx_start_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (tx_st_r == asp_pkg::ASP_TX_WAIT && tx_st_nxt == asp_pkg::ASP_TX_START)
        |=> !txd_out) else $error("start bit not low");
    a_tx_first_data: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (tx_st_r == asp_pkg::ASP_TX_START && tx_tick && tx_div_r == `ASP_DIV_LAST)
        |=> txd_out == $past(tx_sh_r[0])) else $error("first data bit wrong");
    a_tx_done_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        tx_set |=> ctrl_r[`ASP_CTRL_TXDONE] && tx_st_r == asp_pkg::ASP_TX_IDLE && txd_out)
        else $error("tx done not flagged");
    a_tx_idle_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        tx_st_r == asp_pkg::ASP_TX_IDLE |-> txd_out) else $error("idle line not high");
    // Receive sequence and acceptance
    a_rx_start_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rx_st_r == asp_pkg::ASP_RX_HUNT && rx_st_nxt == asp_pkg::ASP_RX_BITS)
        |=> rx_div_r == 4'h0 && rx_sh_r == `ASP_SHREG_ONES) else $error("bad rx start");
    a_rx_full_block: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ctrl_r[`ASP_CTRL_RXFULL] |-> !rx_set) else $error("load while full");
    a_rx_mp_filter: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rx_set && ctrl_r[`ASP_CTRL_MP_EN]) |-> rx_load9) else $error("filter fail");
    a_rx_false_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rx_st_r == asp_pkg::ASP_RX_BITS && rx_first_r && rx_tick
        && rx_div_r == `ASP_DIV_LAST && rx_vote) |=> rx_st_r == asp_pkg::ASP_RX_HUNT)
        else $error("false start kept");
    a_rx_one_hunt: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rx_st_r == asp_pkg::ASP_RX_BITS && rx_tick && rx_div_r == `ASP_DIV_LAST
        && !rx_sh_r[8] && mode == asp_pkg::ASP_MODE_ONE)
        |=> rx_st_r == asp_pkg::ASP_RX_HUNT) else $error("mode 1 not hunting");
    a_rx_tail_hunt: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rx_st_r == asp_pkg::ASP_RX_TAIL && rx_tick && rx_div_r == `ASP_DIV_LAST)
        |=> rx_st_r == asp_pkg::ASP_RX_HUNT) else $error("tail too long");
    a_rx_hunt_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rx_st_r == asp_pkg::ASP_RX_HUNT && !ctrl_r[`ASP_CTRL_RX_EN])
        |=> rx_st_r == asp_pkg::ASP_RX_HUNT) else $error("hunt while disabled");
    // Software flag writes and bus answer
    a_sw_flag_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (wr_ctrl && !tx_set && !rx_set) |=> ctrl_r[`ASP_CTRL_RXFULL:`ASP_CTRL_TXDONE]
        == $past(wb_dat_in[`ASP_CTRL_RXFULL:`ASP_CTRL_TXDONE])) else $error("flag write lost");
    a_wb_ack_once: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wb_ack_out |=> !wb_ack_out) else $error("ack held");
endmodule

// ==== sim/asp_remote_peer.sv ====
// Remote serial device: drives frames onto the receive pin, captures transmit frames
// Assumes the bench sets bit length in clocks and frame length in bits
`timescale 1ns/1ps
module asp_remote_peer (
    input wire logic clk_in,
    input wire logic txd_in,
    input wire logic [7:0] bit_clks_in,
    input wire logic [3:0] frame_bits_in,
    output logic rxd_out,
    output logic [9:0] got_word_out,
    output logic [7:0] got_cnt_out
);
    logic [9:0] w;
    int i;

    // Line idles high through its pull-up
    initial begin
        rxd_out = 1'b1;
        got_cnt_out = 8'h00;
        got_word_out = 10'h000;
    end

    // Capture one frame mid bit, LSB first, start bit excluded
    always begin
        @(negedge txd_in);
        repeat (bit_clks_in / 2) @(posedge clk_in);
        for (i = 0; i < frame_bits_in - 1; i++) begin
            repeat (bit_clks_in) @(posedge clk_in);
            w[i] = txd_in;
        end
        got_word_out = w;
        got_cnt_out = got_cnt_out + 8'h01;
    end

    // Send one frame: start, eight data bits, optional ninth, stop
    task automatic send(input logic [7:0] d, input logic nine, input logic use9,
                        input logic stopv, input logic spike);
        logic [10:0] f;
        int n;
        f = use9 ? {stopv, nine, d, 1'b0} : {1'b0, stopv, d, 1'b0};
        n = use9 ? 11 : 10;
        for (int b = 0; b < n; b++) begin
            for (int c = 0; c < bit_clks_in; c++) begin
                @(posedge clk_in);
                // Optional spike one tick wide inside the first data bit
                rxd_out <= (spike && b == 1 && c >= 32 && c < 36) ? ~f[b] : f[b];
            end
        end
        @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask

    // Short low pulse that must not pass as a start bit
    task automatic glitch(input int n);
        @(posedge clk_in);
        rxd_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask
endmodule

// ==== sim/asp_serial_port_bench.sv ====
// Bench for the serial port: register, transmit and receive scenarios
// Assumes the remote peer model and a 16x tick every four clocks on both timers
`timescale 1ns/1ps
module asp_serial_port_bench;
    localparam int LIMIT = 40000;
    logic clk, rst, we, cyc, stb, ack, tick, rxd, txd, irq;
    logic [3:0] adr, fbits;
    logic [31:0] wdat, rdat, q;
    logic [1:0] tdiv;
    logic [7:0] bitc, last, gcnt;
    logic [9:0] got;
    int fails, compares, cycles;

    asp_serial_port asp_serial_port_inst (.sys_clk_in(clk), .rst_in(rst), .wb_adr_in(adr),
        .wb_dat_in(wdat), .wb_sel_in(4'hf), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_dat_out(rdat), .wb_ack_out(ack), .tmr1_ovf_in(tick), .tmr2_ovf_in(tick),
        .rxd_in(rxd), .txd_out(txd), .serial_irq_out(irq));
    asp_remote_peer asp_remote_peer_inst (.clk_in(clk), .txd_in(txd), .bit_clks_in(bitc),
        .frame_bits_in(fbits), .rxd_out(rxd), .got_word_out(got), .got_cnt_out(gcnt));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Timer pulses every four clocks and the run limit
    always @(posedge clk) begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares = compares + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic w,
                      output logic [31:0] r);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // Reset values, unmapped place, software flag set and clear
    task automatic t_regs();
        wb(4'h0, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        wb(4'h8, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        wb(4'hc, 32'h5a, 1'b1, q);
        wb(4'hc, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        chk({31'h0, txd}, 32'h1);
        wb(4'h0, 32'h80, 1'b1, q);
        irq_is(1'b1);
        wb(4'h0, 32'h40, 1'b1, q);
        wb(4'h0, 32'h0, 1'b0, q);
        chk(q, 32'h40);
        irq_is(1'b1);
        wb(4'h0, 32'h0, 1'b1, q);
        irq_is(1'b0);
        $display("test regs done");
    endtask

    // One transmitted frame: timing of the done flag and the bits on the pin
    task automatic t_tx(input logic [1:0] m, input logic nine, input logic dbl,
                        input logic [7:0] b, input logic [7:0] d);
        logic [10:0] c;
        logic [9:0] e;
        int t0, n0, lo;
        c = {2'b11, dbl, 3'b000, nine, 2'b00, m};
        bitc = b;
        fbits = (m == 2'h1) ? 4'ha : 4'hb;
        lo = ((m == 2'h1) ? 9 : 10) * b;
        wb(4'h0, {21'h0, c}, 1'b1, q);
        n0 = gcnt;
        wb(4'h4, {24'h0, d}, 1'b1, q);
        t0 = cycles;
        while (irq !== 1'b1 && cycles - t0 < 2000) @(posedge clk);
        chk({31'h0, cycles - t0 >= lo && cycles - t0 <= lo + b + 8}, 32'h1);
        while (gcnt == n0 && cycles - t0 < 2000) @(posedge clk);
        e = (m == 2'h1) ? {2'b01, d} : {1'b1, nine, d};
        chk({22'h0, (m == 2'h1) ? {1'b0, got[8:0]} : got}, {22'h0, e});
        wb(4'h0, 32'h0, 1'b0, q);
        chk(q, {21'h0, c | 11'h040});
        wb(4'h0, {21'h0, c}, 1'b1, q);
        irq_is(1'b0);
        $display("test tx mode %0d done", m);
    endtask

    // One received frame: flags, ninth bit, buffer contents, interrupt level
    task automatic t_rx(input logic [1:0] m, input logic [2:0] hs, input logic en,
                        input logic [7:0] b, input logic mp, input logic pre,
                        input logic [7:0] d, input logic nine, input logic stopv,
                        input logic spike, input logic ok);
        logic [10:0] c;
        c = {hs, pre, 3'b000, mp, en, m};
        bitc = b;
        wb(4'h0, {21'h0, c}, 1'b1, q);
        asp_remote_peer_inst.send(d, nine, m != 2'h1, stopv, spike);
        repeat (8) @(posedge clk);
        wb(4'h0, 32'h0, 1'b0, q);
        chk({29'h0, q[7:5]}, {29'h0, ok | pre, 1'b0, ok & ((m == 2'h1) ? stopv : nine)});
        if (ok) last = d;
        wb(4'h4, 32'h0, 1'b0, q);
        chk({24'h0, q[7:0]}, {24'h0, last});
        irq_is(ok | pre);
        wb(4'h0, {21'h0, c & 11'h77f}, 1'b1, q);
        irq_is(1'b0);
        $display("test rx mode %0d done", m);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        wdat = 32'h0;
        tdiv = 2'h0;
        tick = 1'b0;
        fails = 0;
        compares = 0;
        cycles = 0;
        bitc = 8'h40;
        fbits = 4'ha;
        last = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_tx(2'h1, 1'b0, 1'b0, 8'h40, 8'ha5);
        t_tx(2'h3, 1'b1, 1'b0, 8'h40, 8'h3c);
        t_tx(2'h2, 1'b0, 1'b1, 8'h20, 8'hc3);
        t_rx(2'h1, 3'h6, 1'b1, 8'h40, 1'b1, 1'b0, 8'h5a, 1'b0, 1'b1, 1'b1, 1'b1);
        t_rx(2'h1, 3'h2, 1'b1, 8'h80, 1'b0, 1'b0, 8'he7, 1'b0, 1'b1, 1'b0, 1'b1);
        t_rx(2'h1, 3'h3, 1'b1, 8'h40, 1'b0, 1'b1, 8'h11, 1'b0, 1'b1, 1'b0, 1'b0);
        t_rx(2'h3, 3'h6, 1'b1, 8'h40, 1'b1, 1'b0, 8'h22, 1'b0, 1'b1, 1'b0, 1'b0);
        t_rx(2'h3, 3'h6, 1'b1, 8'h40, 1'b1, 1'b0, 8'h9b, 1'b1, 1'b0, 1'b0, 1'b1);
        t_rx(2'h2, 3'h1, 1'b1, 8'h20, 1'b0, 1'b0, 8'h6e, 1'b0, 1'b1, 1'b0, 1'b1);
        t_rx(2'h1, 3'h6, 1'b0, 8'h40, 1'b0, 1'b0, 8'h44, 1'b0, 1'b1, 1'b0, 1'b0);
        wb(4'h0, 32'h605, 1'b1, q);
        asp_remote_peer_inst.glitch(8);
        repeat (128) @(posedge clk);
        t_rx(2'h1, 3'h6, 1'b1, 8'h40, 1'b0, 1'b0, 8'h3f, 1'b0, 1'b1, 1'b0, 1'b1);
        summarize();
    end
endmodule
